//--- rtl/mpr_regs.svh
// Register offsets, field positions, reset values and rate counts
`ifndef MPR_REGS_SVH
`define MPR_REGS_SVH

// Register addresses (5-bit address field of the command byte)
`define MPR_ADDR_ACT_ENERGY   5'h02
`define MPR_ADDR_LINE_ENERGY  5'h04
`define MPR_ADDR_MODE         5'h09
`define MPR_ADDR_IRQ_MASK     5'h0A
`define MPR_ADDR_IRQ_STATUS   5'h0B
`define MPR_ADDR_GAIN         5'h0C
`define MPR_ADDR_PHASE_CAL    5'h10
`define MPR_ADDR_PULSE_NUM    5'h14
`define MPR_ADDR_PULSE_DEN    5'h15
`define MPR_ADDR_HALF_CYCLES  5'h1C
`define MPR_ADDR_BIT_SUM      5'h1E

// Command byte layout
`define MPR_CMD_WRITE_BIT     7
`define MPR_CMD_BITS          4'h8

// Mode register fields
`define MPR_MODE_CYCLE_BIT    7
`define MPR_MODE_SUSPEND_BIT  4
`define MPR_MODE_WSEL_LSB     13

// Interrupt status / mask fields
`define MPR_IRQ_CYCLE_END_BIT 2

// Reset values
`define MPR_MODE_RST          16'h000C
`define MPR_IRQ_MASK_RST      8'h00
`define MPR_HALF_CYCLES_RST   16'hFFFF
`define MPR_GAIN_RST          12'h000
`define MPR_PHASE_CAL_RST     6'h0D
`define MPR_PULSE_NUM_RST     12'h000
`define MPR_PULSE_DEN_RST     12'h03F

// Rates of the master clock: energy and Nyquist as divide-by-N minus one, wave base as N
`define MPR_ENERGY_DIV_M1     10'h003
`define MPR_NYQUIST_DIV_M1    10'h007
`define MPR_WAVE_DIV_BASE     11'h080

// Energy datapath sizing: 2^27 = 4 (update period) * 2^25
`define MPR_DFC_FRAC_BITS     25
`define MPR_GAIN_SHIFT        12
`define MPR_BIT_SUM_W         6

`endif

//--- rtl/mpr_pkg.sv
// Types shared by the metering pulse/rate/checksum block
package mpr_pkg;

  typedef enum logic [3:0] {
    MPR_ST_IDLE  = 4'b0001,
    MPR_ST_CMD   = 4'b0010,
    MPR_ST_READ  = 4'b0100,
    MPR_ST_WRITE = 4'b1000
  } mpr_ser_state_t;

  typedef logic [23:0] mpr_word_t;

endpackage

//--- rtl/mpr_rate_div.sv
// Programmable divide-by-N strobe generator on the master clock
`timescale 1ns/1ps
module mpr_rate_div
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Divider setting, N minus one
  input  wire logic [9:0] div_m1,
  // One-cycle strobe every N clocks
  output logic            strobe_ff
);

  logic [9:0] cnt_ff;
  logic       wrap;

  assign wrap = (cnt_ff >= div_m1);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cnt_ff    <= 10'h000;
      strobe_ff <= 1'b0;
    end
    else
    begin
      cnt_ff    <= wrap ? 10'h000 : cnt_ff + 10'h001;
      strobe_ff <= wrap;
    end
  end

endmodule

//--- rtl/mpr_pulse_div.sv
// Rational pulse-rate scaler: out rate = in rate * (num+1)/(den+1)
`timescale 1ns/1ps
module mpr_pulse_div
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Ratio setting
  input  wire logic [11:0] num,
  input  wire logic [11:0] den,
  // Pulses
  input  wire logic        pulse_in,
  output logic             pulse_out_ff
);

  logic [13:0] acc_ff;
  logic [13:0] step;
  logic [13:0] limit;
  logic [13:0] sum;
  logic        emit;

  assign step  = {2'b00, num} + 14'h0001;
  assign limit = {2'b00, den} + 14'h0001;
  assign sum   = acc_ff + (pulse_in ? step : 14'h0000);
  // Ratios above one are clipped to one output pulse per input pulse
  assign emit  = (sum >= limit);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      acc_ff       <= 14'h0000;
      pulse_out_ff <= 1'b0;
    end
    else
    begin
      acc_ff       <= emit ? ((sum - limit) % limit) : sum;
      pulse_out_ff <= emit;
    end
  end

endmodule

//--- rtl/mpr_core.sv
// Energy pulse, clock-derived rates, suspend and serial read checksum
`timescale 1ns/1ps
`include "mpr_regs.svh"

module mpr_core
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Serial port
  input  wire logic        ser_clk,
  input  wire logic        ser_sel_b,
  input  wire logic        ser_din,
  output logic             ser_dout_ff,
  output logic             ser_dout_oe_ff,
  // Metering datapath
  input  wire logic [23:0] power_avg,
  input  wire logic        zero_cross,
  input  wire logic [23:0] adc_sample,
  // Derived strobes and waveform
  output logic             adc_strobe_ff,
  output logic             phase_strobe_ff,
  output logic [23:0]      wave_sample_ff,
  output logic             wave_valid_ff,
  // Pulse and interrupt pins
  output logic             energy_pulse_output_ff,
  output logic             irq_b_ff
);

  // Configuration and state registers
  logic [15:0] mode_ff;
  logic [7:0]  irq_mask_ff;
  logic [7:0]  irq_status_ff;
  logic [15:0] half_cycle_count_cfg_ff;
  logic [11:0] active_power_gain_cfg_ff;
  logic [5:0]  phase_cal_ff;
  logic [11:0] pulse_num_ff;
  logic [11:0] pulse_den_ff;
  logic [23:0] line_cycle_energy_accum_ff;
  logic [23:0] active_energy_accum_ff;
  logic [`MPR_BIT_SUM_W-1:0] serial_read_bit_sum_ff;

  // Serial engine
  mpr_pkg::mpr_ser_state_t state_ff;
  logic                    sclk_q_ff;
  logic [7:0]              cmd_ff;
  logic [23:0]             shift_ff;
  logic [4:0]              bits_left_ff;
  logic                    load_pending_ff;
  logic [23:0]             rd_word_ff;

  // Energy datapath
  logic [24:0] frac_ff;
  logic [23:0] line_run_ff;
  logic [15:0] half_left_ff;
  logic        line_active_ff;
  logic        dfc_pulse_ff;
  logic [5:0]  phase_left_ff;
  logic        phase_busy_ff;

  // Strobes from the rate dividers
  logic        energy_tick;
  logic        nyq_tick;
  logic        wave_tick;
  logic        pulse_div_out;
  logic [9:0]  wave_div_m1;
  logic [10:0] wave_div;

  // Serial edge detection; the serial clock is a plain input here
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sel_idle;
  logic        cmd_done;
  logic [4:0]  addr;
  logic [1:0]  reg_bytes;
  logic [4:0]  reg_bits;
  logic [23:0] reg_rdata;
  logic        read_start;
  logic        read_bit;
  logic        read_end;
  logic        write_end;
  logic [23:0] wdata;

  // Energy computation wires
  logic signed [24:0] power_s;
  logic signed [36:0] gain_prod;
  logic signed [25:0] scaled_s;
  logic [24:0]        scaled;
  logic [25:0]        frac_sum;
  logic               cycle_mode;
  logic               suspend;
  logic               cycle_end;
  logic               status_read;

  assign sclk_rise = ser_clk & ~sclk_q_ff;
  assign sclk_fall = ~ser_clk & sclk_q_ff;
  assign sel_idle  = ser_sel_b;
  assign addr      = cmd_ff[4:0];
  assign cmd_done  = (state_ff == mpr_pkg::MPR_ST_CMD) && sclk_fall
                     && (bits_left_ff == 5'h01);
  assign wdata     = {shift_ff[22:0], ser_din};

  // Width and contents of each readable register, right justified
  always_comb
  begin
    reg_bytes = 2'd0;
    reg_rdata = 24'h000000;
    case ({cmd_ff[6:5], addr[4:0]} & 7'h1F)
      {2'b00, `MPR_ADDR_ACT_ENERGY}:
      begin
        reg_bytes = 2'd3;
        reg_rdata = active_energy_accum_ff;
      end
      {2'b00, `MPR_ADDR_LINE_ENERGY}:
      begin
        reg_bytes = 2'd3;
        reg_rdata = line_cycle_energy_accum_ff;
      end
      {2'b00, `MPR_ADDR_MODE}:
      begin
        reg_bytes = 2'd2;
        reg_rdata = {8'h00, mode_ff};
      end
      {2'b00, `MPR_ADDR_IRQ_MASK}:
      begin
        reg_bytes = 2'd1;
        reg_rdata = {16'h0000, irq_mask_ff};
      end
      {2'b00, `MPR_ADDR_IRQ_STATUS}:
      begin
        reg_bytes = 2'd1;
        reg_rdata = {16'h0000, irq_status_ff};
      end
      {2'b00, `MPR_ADDR_GAIN}:
      begin
        reg_bytes = 2'd2;
        reg_rdata = {12'h000, active_power_gain_cfg_ff};
      end
      {2'b00, `MPR_ADDR_PHASE_CAL}:
      begin
        reg_bytes = 2'd1;
        reg_rdata = {18'h00000, phase_cal_ff};
      end
      {2'b00, `MPR_ADDR_PULSE_NUM}:
      begin
        reg_bytes = 2'd2;
        reg_rdata = {12'h000, pulse_num_ff};
      end
      {2'b00, `MPR_ADDR_PULSE_DEN}:
      begin
        reg_bytes = 2'd2;
        reg_rdata = {12'h000, pulse_den_ff};
      end
      {2'b00, `MPR_ADDR_HALF_CYCLES}:
      begin
        reg_bytes = 2'd2;
        reg_rdata = {8'h00, half_cycle_count_cfg_ff};
      end
      {2'b00, `MPR_ADDR_BIT_SUM}:
      begin
        reg_bytes = 2'd1;
        reg_rdata = {18'h00000, serial_read_bit_sum_ff};
      end
      default:
      begin
        reg_bytes = 2'd1;
        reg_rdata = 24'h000000;
      end
    endcase
  end

  assign reg_bits   = {reg_bytes, 3'b000};
  // Checksum restarts here, on the falling edge before the MSB goes out
  assign read_start = cmd_done && !wdata[`MPR_CMD_WRITE_BIT];
  assign read_bit   = (state_ff == mpr_pkg::MPR_ST_READ) && sclk_rise
                      && (bits_left_ff != 5'h00);
  assign read_end   = (state_ff == mpr_pkg::MPR_ST_READ) && sclk_fall
                      && (bits_left_ff == 5'h00);
  assign write_end  = (state_ff == mpr_pkg::MPR_ST_WRITE) && sclk_fall
                      && (bits_left_ff == 5'h01);
  // Cleared as the word is captured, so the read still shows the flag
  assign status_read = load_pending_ff
                       && (addr == `MPR_ADDR_IRQ_STATUS);

  // Serial state machine
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_ff     <= mpr_pkg::MPR_ST_IDLE;
      sclk_q_ff    <= 1'b0;
      cmd_ff       <= 8'h00;
      shift_ff     <= 24'h000000;
      bits_left_ff <= 5'h00;
    end
    else
    begin
      sclk_q_ff <= ser_clk;
      if (sel_idle)
      begin
        state_ff <= mpr_pkg::MPR_ST_IDLE;
      end
      else
      begin
        case (state_ff)
          mpr_pkg::MPR_ST_IDLE:
          begin
            state_ff     <= mpr_pkg::MPR_ST_CMD;
            bits_left_ff <= {1'b0, `MPR_CMD_BITS};
          end
          mpr_pkg::MPR_ST_CMD:
          begin
            if (sclk_fall)
            begin
              shift_ff     <= wdata;
              bits_left_ff <= bits_left_ff - 5'h01;
            end
            if (cmd_done)
            begin
              cmd_ff <= wdata[7:0];
              // Read path loads the word below once cmd_ff settles
              state_ff <= wdata[`MPR_CMD_WRITE_BIT] ?
                          mpr_pkg::MPR_ST_WRITE : mpr_pkg::MPR_ST_READ;
              bits_left_ff <= 5'h00;
            end
          end
          mpr_pkg::MPR_ST_READ:
          begin
            // Bit count waits a cycle for cmd_ff to pick the register
            if (load_pending_ff)
            begin
              bits_left_ff <= reg_bits;
            end
            else if (read_bit)
            begin
              bits_left_ff <= bits_left_ff - 5'h01;
            end
            if (read_end)
            begin
              state_ff     <= mpr_pkg::MPR_ST_CMD;
              bits_left_ff <= {1'b0, `MPR_CMD_BITS};
            end
          end
          mpr_pkg::MPR_ST_WRITE:
          begin
            if (bits_left_ff == 5'h00)
            begin
              bits_left_ff <= reg_bits;
            end
            else if (sclk_fall)
            begin
              shift_ff     <= wdata;
              bits_left_ff <= bits_left_ff - 5'h01;
            end
            if (write_end)
            begin
              state_ff     <= mpr_pkg::MPR_ST_CMD;
              bits_left_ff <= {1'b0, `MPR_CMD_BITS};
            end
          end
          default:
          begin
            state_ff <= mpr_pkg::MPR_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Data out: loaded at read start, advanced on rising serial edges
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ser_dout_ff     <= 1'b0;
      ser_dout_oe_ff  <= 1'b0;
      load_pending_ff <= 1'b0;
    end
    else
    begin
      load_pending_ff <= read_start;
      if (sel_idle || read_end)
      begin
        ser_dout_oe_ff <= 1'b0;
      end
      else if (read_bit)
      begin
        ser_dout_oe_ff <= 1'b1;
        ser_dout_ff    <= rd_word_ff[23];
      end
    end
  end

  // Whole word captured at once so multi-byte reads stay coherent
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rd_word_ff <= 24'h000000;
    end
    else if (load_pending_ff)
    begin
      rd_word_ff <= reg_rdata << (5'd24 - reg_bits);
    end
    else if (read_bit)
    begin
      rd_word_ff <= {rd_word_ff[22:0], 1'b0};
    end
  end

  // Checksum: cleared at read start, then counts each one bit sent
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      serial_read_bit_sum_ff <= 6'h00;
    end
    else if (load_pending_ff)
    begin
      serial_read_bit_sum_ff <= 6'h00;
    end
    else if (read_bit && rd_word_ff[23])
    begin
      serial_read_bit_sum_ff <= serial_read_bit_sum_ff + 6'h01;
    end
  end

  // Writable registers; unmapped and read-only targets drop the data
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      mode_ff                  <= `MPR_MODE_RST;
      irq_mask_ff              <= `MPR_IRQ_MASK_RST;
      half_cycle_count_cfg_ff  <= `MPR_HALF_CYCLES_RST;
      active_power_gain_cfg_ff <= `MPR_GAIN_RST;
      phase_cal_ff             <= `MPR_PHASE_CAL_RST;
      pulse_num_ff             <= `MPR_PULSE_NUM_RST;
      pulse_den_ff             <= `MPR_PULSE_DEN_RST;
    end
    else if (write_end && !sel_idle)
    begin
      case (addr)
        `MPR_ADDR_MODE:        mode_ff                  <= wdata[15:0];
        `MPR_ADDR_IRQ_MASK:    irq_mask_ff              <= wdata[7:0];
        `MPR_ADDR_HALF_CYCLES: half_cycle_count_cfg_ff  <= wdata[15:0];
        `MPR_ADDR_GAIN:        active_power_gain_cfg_ff <= wdata[11:0];
        `MPR_ADDR_PHASE_CAL:   phase_cal_ff             <= wdata[5:0];
        `MPR_ADDR_PULSE_NUM:   pulse_num_ff             <= wdata[11:0];
        `MPR_ADDR_PULSE_DEN:   pulse_den_ff             <= wdata[11:0];
        default:               mode_ff                  <= mode_ff;
      endcase
    end
  end

  // Rates derived from the master clock alone
  mpr_rate_div u_energy_div
  (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .div_m1    (`MPR_ENERGY_DIV_M1),
    .strobe_ff (energy_tick)
  );

  mpr_rate_div u_nyq_div
  (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .div_m1    (`MPR_NYQUIST_DIV_M1),
    .strobe_ff (nyq_tick)
  );

  assign wave_div    = `MPR_WAVE_DIV_BASE
                       << mode_ff[`MPR_MODE_WSEL_LSB +: 2];
  assign wave_div_m1 = 10'(wave_div - 11'h001);

  mpr_rate_div u_wave_div
  (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .div_m1    (wave_div_m1),
    .strobe_ff (wave_tick)
  );

  // Gain scaled power, 1 + gain/4096; negative results clamp to zero
  assign power_s   = $signed({1'b0, power_avg});
  assign gain_prod = power_s * $signed(active_power_gain_cfg_ff);
  assign scaled_s  = 26'(power_s)
                     + 26'(gain_prod >>> `MPR_GAIN_SHIFT);
  assign scaled    = scaled_s[25] ? 25'h0 : scaled_s[24:0];
  // Carry out of 2^25 every 4 clocks gives avg*clk/2^27 pulses
  assign frac_sum  = {1'b0, frac_ff} + {1'b0, scaled};
  assign cycle_mode = mode_ff[`MPR_MODE_CYCLE_BIT];
  assign suspend    = mode_ff[`MPR_MODE_SUSPEND_BIT];
  assign cycle_end  = line_active_ff && zero_cross
                      && (half_left_ff == 16'h0001);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      frac_ff                    <= 25'h0;
      dfc_pulse_ff               <= 1'b0;
      active_energy_accum_ff     <= 24'h000000;
      line_run_ff                <= 24'h000000;
      line_cycle_energy_accum_ff <= 24'h000000;
      half_left_ff               <= 16'h0000;
      line_active_ff             <= 1'b0;
    end
    else
    begin
      dfc_pulse_ff <= energy_tick && frac_sum[25];
      if (energy_tick)
      begin
        frac_ff <= frac_sum[24:0];
      end
      if (dfc_pulse_ff)
      begin
        active_energy_accum_ff <= active_energy_accum_ff + 24'h000001;
      end
      // Window opens on a zero crossing so it spans whole half cycles
      if (!cycle_mode)
      begin
        line_active_ff <= 1'b0;
      end
      else if (zero_cross && !line_active_ff)
      begin
        line_active_ff <= 1'b1;
        half_left_ff   <= half_cycle_count_cfg_ff;
        line_run_ff    <= 24'h000000;
      end
      else if (line_active_ff)
      begin
        if (cycle_end)
        begin
          line_cycle_energy_accum_ff <= line_run_ff
                                        + {23'h0, dfc_pulse_ff};
          line_run_ff  <= 24'h000000;
          half_left_ff <= half_cycle_count_cfg_ff;
        end
        else
        begin
          line_run_ff <= line_run_ff + {23'h0, dfc_pulse_ff};
          if (zero_cross)
          begin
            half_left_ff <= half_left_ff - 16'h0001;
          end
        end
      end
    end
  end

  // Interrupt: set wins over clear-on-read
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      irq_status_ff <= 8'h00;
      irq_b_ff      <= 1'b1;
    end
    else
    begin
      irq_status_ff[`MPR_IRQ_CYCLE_END_BIT] <= cycle_end
        || (irq_status_ff[`MPR_IRQ_CYCLE_END_BIT] && !status_read);
      irq_b_ff <= !((irq_status_ff & irq_mask_ff) != 8'h00);
    end
  end

  // Energy pulse divider
  mpr_pulse_div u_pulse_div
  (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .num          (pulse_num_ff),
    .den          (pulse_den_ff),
    .pulse_in     (dfc_pulse_ff),
    .pulse_out_ff (pulse_div_out)
  );

  // Phase step: ch2 sample strobe trails by phase_cal * 4 clocks
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      phase_left_ff          <= 6'h00;
      phase_busy_ff          <= 1'b0;
      phase_strobe_ff        <= 1'b0;
      adc_strobe_ff          <= 1'b0;
      wave_sample_ff         <= 24'h000000;
      wave_valid_ff          <= 1'b0;
      energy_pulse_output_ff <= 1'b0;
    end
    else
    begin
      adc_strobe_ff          <= nyq_tick;
      energy_pulse_output_ff <= pulse_div_out;
      phase_strobe_ff        <= 1'b0;
      // One countdown at a time; strobes during it start no new one
      if (phase_busy_ff && phase_left_ff == 6'h00)
      begin
        phase_busy_ff   <= 1'b0;
        phase_strobe_ff <= 1'b1;
      end
      else if (phase_busy_ff && energy_tick)
      begin
        phase_left_ff <= phase_left_ff - 6'h01;
      end
      else if (nyq_tick && !phase_busy_ff)
      begin
        phase_left_ff <= phase_cal_ff;
        phase_busy_ff <= 1'b1;
      end
      wave_valid_ff <= wave_tick;
      if (wave_tick)
      begin
        // Suspend only zeroes the waveform sample; host clears suspend to resume
        wave_sample_ff <= suspend ? 24'h000000 : adc_sample;
      end
    end
  end

endmodule

//--- bench/mpr_core_asserts.sv
// Port-level checker for the metering pulse, rate and checksum core
`timescale 1ns/1ps
module mpr_core_asserts
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Observed pins
  input wire logic ser_clk,
  input wire logic ser_sel_b,
  input wire logic zero_cross,
  input wire logic ser_dout_ff,
  input wire logic ser_dout_oe_ff,
  input wire logic adc_strobe_ff,
  input wire logic phase_strobe_ff,
  input wire logic wave_valid_ff,
  input wire logic energy_pulse_output_ff,
  input wire logic irq_b_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [10:0] gap_ff;
  logic [10:0] nxt_gap;
  // Saturates so a long idle never wraps into a short gap
  assign nxt_gap = wave_valid_ff ? 11'h000 :
                   (gap_ff == 11'h7FF) ? gap_ff : gap_ff + 11'h001;
  always_ff @(posedge core_clk)
    gap_ff <= rst_b ? nxt_gap : 11'h7FF;
  property p_adc; adc_strobe_ff |=> !adc_strobe_ff [*7] ##1 adc_strobe_ff;
  endproperty
  a_adc: assert property (p_adc) else $error("adc strobe gap");
  property p_phase; phase_strobe_ff |=> !phase_strobe_ff [*7]; endproperty
  a_phase: assert property (p_phase) else $error("phase gap");
  property p_pulse; energy_pulse_output_ff |=> !energy_pulse_output_ff [*3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse gap");
  property p_wave; wave_valid_ff |-> gap_ff >= 11'h07F; endproperty
  a_wave: assert property (p_wave) else $error("wave gap");
  property p_dout; ser_dout_oe_ff && $past(ser_dout_oe_ff) &&
    $changed(ser_dout_ff) |-> $past(ser_clk) || $past(ser_clk, 2) ||
    $past(ser_clk, 3); endproperty
  a_dout: assert property (p_dout) else $error("dout edge");
  property p_sel; $rose(ser_sel_b) |-> ##[0:3] !ser_dout_oe_ff; endproperty
  a_sel: assert property (p_sel) else $error("oe after sel");
  property p_irq; $fell(irq_b_ff) |-> $past(zero_cross) ||
    $past(zero_cross, 2) || $past(zero_cross, 3) || !$past(ser_sel_b, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq cause");
  property p_rst; $rose(rst_b) |-> irq_b_ff && !ser_dout_oe_ff &&
    !energy_pulse_output_ff; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind mpr_core mpr_core_asserts u_chk (.core_clk, .rst_b, .ser_clk,
  .ser_sel_b, .zero_cross, .ser_dout_ff, .ser_dout_oe_ff, .adc_strobe_ff,
  .phase_strobe_ff, .wave_valid_ff, .energy_pulse_output_ff, .irq_b_ff);

//--- bench/mpr_host_model.sv
// Host serial master model driving the core's serial port
`timescale 1ns/1ps
module mpr_host_model
(
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic     ser_clk,
  output logic     ser_sel_b,
  output logic     ser_din,
  input wire logic ser_dout_ff,
  input wire logic ser_dout_oe_ff
);
  initial
  begin
    ser_clk = 1'b0;
    ser_sel_b = 1'b1;
    ser_din = 1'b0;
  end
  // Four core cycles a phase, above the three-cycle minimum
  task automatic bit1(input logic b, output logic r);
    @(negedge core_clk) ser_clk = 1'b1;
    ser_din = b;
    repeat (4) @(negedge core_clk);
    r = ser_dout_oe_ff ? ser_dout_ff : 1'bx;
    ser_clk = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic xfer(input logic [7:0] cmd, input int nb,
                      input logic [23:0] wd, output logic [23:0] rd);
    logic r;
    rd = 24'h0;
    @(negedge core_clk) ser_sel_b = 1'b0;
    for (int i = 7; i >= 0; i--) bit1(cmd[i], r);
    for (int i = nb - 1; i >= 0; i--)
    begin
      bit1(wd[i], r);
      rd = {rd[22:0], r};
    end
    @(negedge core_clk) ser_sel_b = 1'b1;
    // Released line must not keep showing the last bit
    ser_din = ~ser_din;
    repeat (4) @(negedge core_clk);
  endtask
endmodule

//--- bench/mpr_core_tb.sv
// Self-checking bench for the metering core
`timescale 1ns/1ps
module mpr_core_tb;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        zero_cross = 1'b0;
  logic [23:0] power_avg = 24'h0;
  logic [23:0] adc_sample = 24'h5A5A5A;
  logic        ser_clk, ser_sel_b, ser_din, ser_dout_ff, ser_dout_oe_ff;
  logic        adc_strobe_ff, phase_strobe_ff, wave_valid_ff, irq_b_ff;
  logic        energy_pulse_output_ff;
  logic [23:0] wave_sample_ff, rd;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cnt = 0;
  int          n;
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (energy_pulse_output_ff === 1'b1) cnt++;
  mpr_core dut (.core_clk, .rst_b, .ser_clk, .ser_sel_b, .ser_din,
    .ser_dout_ff, .ser_dout_oe_ff, .power_avg, .zero_cross, .adc_sample,
    .adc_strobe_ff, .phase_strobe_ff, .wave_sample_ff, .wave_valid_ff,
    .energy_pulse_output_ff, .irq_b_ff);
  mpr_host_model host (.core_clk, .ser_clk, .ser_sel_b, .ser_din,
    .ser_dout_ff, .ser_dout_oe_ff);
  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Edge effects of a counting window allow one count either way
  task automatic near(string nm, int exp, logic [23:0] got);
    chk(nm, 24'(exp), (got >= exp - 1 && got <= exp + 1) ? 24'(exp) : got);
  endtask
  task automatic rg(string nm, logic [4:0] a, int nb, logic [23:0] exp);
    host.xfer({3'h0, a}, nb, 24'h0, rd);
    chk(nm, exp, rd);
  endtask
  task automatic wr(logic [4:0] a, int nb, logic [23:0] v);
    host.xfer({3'h4, a}, nb, v, rd);
  endtask
  // Half of full power carries once every 16 clocks
  task automatic rate(string nm, int exp);
    @(negedge core_clk) power_avg = 24'h800000;
    cnt = 0;
    repeat (1600) @(negedge core_clk);
    power_avg = 24'h0;
    near(nm, exp, 24'(cnt));
  endtask
  task automatic wv(output int k);
    k = 0;
    do @(negedge core_clk) k++; while (wave_valid_ff !== 1'b1 && k < 3000);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    rg("mode", 5'h09, 16, 24'h00000C);
    rg("sum", 5'h1E, 8, 24'h000002);
    rg("sum", 5'h1E, 8, 24'h000001);
    wr(5'h1E, 8, 24'h00003F);
    rg("sum", 5'h1E, 8, 24'h000001);
    rg("half", 5'h1C, 16, 24'h00FFFF);
    rg("sum", 5'h1E, 8, 24'h000010);
    rg("den", 5'h15, 16, 24'h00003F);
    rg("phase", 5'h10, 8, 24'h00000D);
    rg("none", 5'h1F, 8, 24'h000000);
    $display("test registers done");
    wr(5'h15, 16, 24'h0);
    rate("pulse", 100);
    host.xfer(8'h02, 24, 24'h0, rd);
    near("energy", 100, rd);
    wr(5'h14, 16, 24'h2);
    wr(5'h15, 16, 24'h5);
    rate("ratio", 50);
    wr(5'h14, 16, 24'h0);
    wr(5'h15, 16, 24'h0);
    wr(5'h0C, 16, 24'h000800);
    rate("gain", 50);
    wr(5'h0C, 16, 24'h0);
    $display("test pulse done");
    wr(5'h1C, 16, 24'h2);
    wr(5'h0A, 8, 24'h04);
    wr(5'h09, 16, 24'h00008C);
    @(negedge core_clk) power_avg = 24'h800000;
    for (int i = 0; i < 4; i++)
    begin
      repeat (160) @(negedge core_clk);
      zero_cross = 1'b1;
      @(negedge core_clk) zero_cross = 1'b0;
    end
    power_avg = 24'h0;
    chk("irq", 24'h0, 24'(irq_b_ff));
    rg("status", 5'h0B, 8, 24'h000004);
    chk("irq", 24'h1, 24'(irq_b_ff));
    host.xfer(8'h04, 24, 24'h0, rd);
    near("line", 20, rd);
    $display("test line done");
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h09, 16, (24'(k) << 13) | 24'h00000C);
      wv(n);
      wv(n);
      wv(n);
      chk("wave", 24'(128 << k), 24'(n));
    end
    $display("test wave done");
    wr(5'h09, 16, 24'h00001C);
    wv(n);
    wv(n);
    chk("susp", 24'h0, wave_sample_ff);
    wr(5'h09, 16, 24'h00000C);
    wv(n);
    wv(n);
    chk("wake", 24'h5A5A5A, wave_sample_ff);
    $display("test suspend done");
    report_and_stop;
  end
endmodule
